/* pkg/vcc_cfg.svh */
// Register offsets, field positions, reset values and fixed codes of the channel capability registers.
`ifndef VCC_CFG_SVH
`define VCC_CFG_SVH
`define VCC_OFS_HLOG0     12'h11C
`define VCC_OFS_HLOG1     12'h120
`define VCC_OFS_HLOG2     12'h124
`define VCC_OFS_HLOG3     12'h128
`define VCC_OFS_CAPHDR    12'h140
`define VCC_OFS_CAP1      12'h144
`define VCC_OFS_CAP2      12'h148
`define VCC_OFS_CTRL      12'h14C
`define VCC_CAP_ID        16'h0002
`define VCC_CAP_VER       4'h1
`define VCC_NEXT_PTR      12'h20C
`define VCC_CNT_RESET     3'h0
`define VCC_REFCLK_100NS  2'h0
`define VCC_ENTRY_SIZE    2'h2
`define VCC_ARB_CAP_ONE   8'h03
`define VCC_ARB_CAP_NONE  8'h00
`define VCC_TBL_OFS_ONE   8'h03
`define VCC_TBL_OFS_NONE  8'h00
`define VCC_LOAD_BIT      0
`define VCC_SEL_LSB       1
`define VCC_SEL_MSB       3
`define VCC_STATUS_BIT    16
`define VCC_SEL_RESET     3'h0
`endif

/* pkg/vcc_pkg.sv */
// Types shared by the channel capability register block.
package vcc_pkg;
  typedef struct packed {
    logic [127:0] hlog;
    logic [2:0]   ext_cnt;
    logic [2:0]   low_priority_channel_group;
    logic [2:0]   arb_sel;
    logic         tbl_status;
    logic         load_pulse;
    logic [31:0]  rdata;
  } vcc_state_type;
endpackage : vcc_pkg

/* rtl/vcc_regs.sv */
// Channel capability registers and captured packet header log behind a plain register port.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "vcc_cfg.svh"
module vcc_regs
(
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [11:0]  addr,
  input  wire logic [31:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [31:0]  rdata,
  input  wire logic         log_event,
  input  wire logic [127:0] log_header,
  input  wire logic         strap_load,
  input  wire logic [2:0]   strap_ext_cnt,
  input  wire logic [2:0]   strap_low_cnt,
  input  wire logic         tbl_entry_write,
  input  wire logic         tbl_load_done,
  output logic              tbl_load,
  output logic      [2:0]   arb_scheme
);
  vcc_pkg::vcc_state_type st;
  vcc_pkg::vcc_state_type next_st;

  // Reads return the big-endian byte order of each header doubleword.
  function automatic logic [31:0] swap_bytes(input logic [31:0] d);
    swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swap_bytes

  function automatic logic [31:0] read_mux(input vcc_pkg::vcc_state_type s, input logic [11:0] a);
    read_mux = 32'h0;
    case (a)
      `VCC_OFS_HLOG0 : read_mux = swap_bytes(s.hlog[31:0]);
      `VCC_OFS_HLOG1 : read_mux = swap_bytes(s.hlog[63:32]);
      `VCC_OFS_HLOG2 : read_mux = swap_bytes(s.hlog[95:64]);
      `VCC_OFS_HLOG3 : read_mux = swap_bytes(s.hlog[127:96]);
      `VCC_OFS_CAPHDR: read_mux = {`VCC_NEXT_PTR, `VCC_CAP_VER, `VCC_CAP_ID};
      `VCC_OFS_CAP1  : read_mux = {20'h0, `VCC_ENTRY_SIZE, `VCC_REFCLK_100NS, 1'b0,
                                   s.low_priority_channel_group, 1'b0, s.ext_cnt};
      `VCC_OFS_CAP2  : read_mux = (s.ext_cnt == 3'h1) ?
                                  {`VCC_TBL_OFS_ONE, 16'h0, `VCC_ARB_CAP_ONE} :
                                  {`VCC_TBL_OFS_NONE, 16'h0, `VCC_ARB_CAP_NONE};
      // Load bit reads zero; status sits alone at bit 16, the lowest bit of the upper half.
      `VCC_OFS_CTRL  : read_mux = {15'h0, s.tbl_status, 12'h0, s.arb_sel, 1'b0};
      default        : read_mux = 32'h0;
    endcase
  endfunction : read_mux

  always_comb
  begin
    next_st = st;
    next_st.load_pulse = 1'b0;
    if (log_event)
    begin
      next_st.hlog = log_header;
    end
    if (strap_load)
    begin
      next_st.ext_cnt = strap_ext_cnt;
      next_st.low_priority_channel_group = strap_low_cnt;
    end
    if (wr && addr == `VCC_OFS_CTRL)
    begin
      next_st.load_pulse = wdata[`VCC_LOAD_BIT];
      next_st.arb_sel = wdata[`VCC_SEL_MSB:`VCC_SEL_LSB];
    end
    if (tbl_load_done)
    begin
      next_st.tbl_status = 1'b0;
    end
    // A table write in the same cycle as completion keeps the flag set.
    if (tbl_entry_write)
    begin
      next_st.tbl_status = 1'b1;
    end
    next_st.rdata = rd ? read_mux(st, addr) : 32'h0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.hlog <= 128'h0;
      st.ext_cnt <= `VCC_CNT_RESET;
      st.low_priority_channel_group <= `VCC_CNT_RESET;
      st.arb_sel <= `VCC_SEL_RESET;
      st.tbl_status <= 1'b0;
      st.load_pulse <= 1'b0;
      st.rdata <= 32'h0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign tbl_load = st.load_pulse;
  // Unsupported schemes fall back to the default one.
  assign arb_scheme = (st.arb_sel <= 3'h1) ? st.arb_sel : 3'h0;

  property p_cap_id;
    @(posedge mclk) disable iff (sys_rst)
    rd && addr == `VCC_OFS_CAPHDR |=> rdata == {`VCC_NEXT_PTR, `VCC_CAP_VER, `VCC_CAP_ID};
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("Capability header wrong.");

  // The load request and its answer are kept as named steps, used by p_load below.
  sequence s_load_req;
    wr && addr == `VCC_OFS_CTRL && wdata[`VCC_LOAD_BIT];
  endsequence

  sequence s_load_pulse;
    tbl_load;
  endsequence

  property p_load;
    @(posedge mclk) disable iff (sys_rst)
    s_load_req |=> s_load_pulse;
  endproperty
  a_load: assert property (p_load) else $error("Table load pulse missing.");

  // Back-to-back load requests are legal, so the pulse may only end when no new request came.
  property p_load_end;
    @(posedge mclk) disable iff (sys_rst)
    tbl_load && !(wr && addr == `VCC_OFS_CTRL && wdata[`VCC_LOAD_BIT]) |=> !tbl_load;
  endproperty
  a_load_end: assert property (p_load_end) else $error("Table load pulse too long.");

  property p_load_only;
    @(posedge mclk) disable iff (sys_rst)
    !(wr && addr == `VCC_OFS_CTRL && wdata[`VCC_LOAD_BIT]) |=> !tbl_load;
  endproperty
  a_load_only: assert property (p_load_only) else $error("Table load without request.");

  property p_load_rd;
    @(posedge mclk) disable iff (sys_rst)
    rd && addr == `VCC_OFS_CTRL |=> rdata[0] == 1'b0;
  endproperty
  a_load_rd: assert property (p_load_rd) else $error("Load bit read nonzero.");

  property p_sel;
    @(posedge mclk) disable iff (sys_rst)
    wr && addr == `VCC_OFS_CTRL && wdata[3:1] > 3'h1 |=> arb_scheme == 3'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("Bad scheme not defaulted.");

  property p_set;
    @(posedge mclk) disable iff (sys_rst)
    tbl_entry_write |=> st.tbl_status;
  endproperty
  a_set: assert property (p_set) else $error("Status not set.");

  property p_clr;
    @(posedge mclk) disable iff (sys_rst)
    tbl_load_done && !tbl_entry_write |=> !st.tbl_status;
  endproperty
  a_clr: assert property (p_clr) else $error("Status not cleared.");

  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
    !log_event |=> $stable(st.hlog);
  endproperty
  a_hold: assert property (p_hold) else $error("Header log changed.");

  property p_cap2;
    @(posedge mclk) disable iff (sys_rst)
    rd && addr == `VCC_OFS_CAP2 && st.ext_cnt == 3'h1 |=> rdata == 32'h03000003;
  endproperty
  a_cap2: assert property (p_cap2) else $error("Capability two wrong.");

  // Every address that answers with something other than zero.
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `VCC_OFS_HLOG0) || (a == `VCC_OFS_HLOG1) ||
                (a == `VCC_OFS_HLOG2) || (a == `VCC_OFS_HLOG3) ||
                (a == `VCC_OFS_CAPHDR) || (a == `VCC_OFS_CAP1) ||
                (a == `VCC_OFS_CAP2) || (a == `VCC_OFS_CTRL);
  endfunction : is_mapped

  sequence s_ctrl_read;
    rd && addr == `VCC_OFS_CTRL;
  endsequence

  sequence s_cap1_read;
    rd && addr == `VCC_OFS_CAP1;
  endsequence

  sequence s_cap2_read;
    rd && addr == `VCC_OFS_CAP2;
  endsequence

  sequence s_hdr_read;
    rd && addr == `VCC_OFS_CAPHDR;
  endsequence

  // One checker per header doubleword; byte zero of each word leads the read data.
  for (genvar g = 0; g < 4; g++)
  begin : g_hlog_chk
    property p_hlog_word;
      @(posedge mclk) disable iff (sys_rst)
      rd && addr == 12'(`VCC_OFS_HLOG0 + 4 * g) |=>
        rdata == {$past(st.hlog[32 * g +: 8]), $past(st.hlog[32 * g + 8 +: 8]),
                  $past(st.hlog[32 * g + 16 +: 8]), $past(st.hlog[32 * g + 24 +: 8])};
    endproperty
    a_hlog_word: assert property (p_hlog_word) else $error("Header log word wrong.");
  end

  // The read port returns zero whenever no read was asked for.
  property p_rd_idle;
    @(posedge mclk) disable iff (sys_rst)
    !rd |=> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("Read data outside read.");

  property p_unmapped;
    @(posedge mclk) disable iff (sys_rst)
    rd && !is_mapped(addr) |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read nonzero.");

  property p_ver;
    @(posedge mclk) disable iff (sys_rst)
    s_hdr_read |=> rdata[19:16] == `VCC_CAP_VER;
  endproperty
  a_ver: assert property (p_ver) else $error("Capability version wrong.");

  property p_next;
    @(posedge mclk) disable iff (sys_rst)
    s_hdr_read |=> rdata[31:20] == `VCC_NEXT_PTR;
  endproperty
  a_next: assert property (p_next) else $error("Next pointer wrong.");

  property p_ext_cnt;
    @(posedge mclk) disable iff (sys_rst)
    s_cap1_read |=> rdata[2:0] == $past(st.ext_cnt);
  endproperty
  a_ext_cnt: assert property (p_ext_cnt) else $error("Extra channel count wrong.");

  property p_low_cnt;
    @(posedge mclk) disable iff (sys_rst)
    s_cap1_read |=> rdata[6:4] == $past(st.low_priority_channel_group);
  endproperty
  a_low_cnt: assert property (p_low_cnt) else $error("Low-priority count wrong.");

  property p_refclk;
    @(posedge mclk) disable iff (sys_rst)
    s_cap1_read |=> rdata[9:8] == `VCC_REFCLK_100NS;
  endproperty
  a_refclk: assert property (p_refclk) else $error("Reference clock field wrong.");

  property p_entry;
    @(posedge mclk) disable iff (sys_rst)
    s_cap1_read |=> rdata[11:10] == `VCC_ENTRY_SIZE;
  endproperty
  a_entry: assert property (p_entry) else $error("Entry size field wrong.");

  // Reserved bits must stay clear so software can extend the word later.
  property p_cap1_rsvd;
    @(posedge mclk) disable iff (sys_rst)
    s_cap1_read |=> rdata[31:12] == 20'h0 && !rdata[3] && !rdata[7];
  endproperty
  a_cap1_rsvd: assert property (p_cap1_rsvd) else $error("Capability one reserved bits set.");

  // The counts are only changed by the strap loaders, never by software writes.
  property p_strap;
    @(posedge mclk) disable iff (sys_rst)
    strap_load |=> st.ext_cnt == $past(strap_ext_cnt) &&
                   st.low_priority_channel_group == $past(strap_low_cnt);
  endproperty
  a_strap: assert property (p_strap) else $error("Strap load missed.");

  property p_cnt_hold;
    @(posedge mclk) disable iff (sys_rst)
    !strap_load |=> $stable(st.ext_cnt) && $stable(st.low_priority_channel_group);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("Count changed without strap.");

  property p_cap2_none;
    @(posedge mclk) disable iff (sys_rst)
    rd && addr == `VCC_OFS_CAP2 && st.ext_cnt != 3'h1 |=> rdata == 32'h0;
  endproperty
  a_cap2_none: assert property (p_cap2_none) else $error("Capability two not zero.");

  property p_tbl_ofs;
    @(posedge mclk) disable iff (sys_rst)
    rd && addr == `VCC_OFS_CAP2 && st.ext_cnt == 3'h1 |=> rdata[31:24] == `VCC_TBL_OFS_ONE;
  endproperty
  a_tbl_ofs: assert property (p_tbl_ofs) else $error("Table offset wrong.");

  property p_cap2_rsvd;
    @(posedge mclk) disable iff (sys_rst)
    s_cap2_read |=> rdata[23:8] == 16'h0;
  endproperty
  a_cap2_rsvd: assert property (p_cap2_rsvd) else $error("Capability two reserved bits set.");

  property p_ctrl_rsvd;
    @(posedge mclk) disable iff (sys_rst)
    s_ctrl_read |=> rdata[15:4] == 12'h0 && rdata[31:17] == 15'h0;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("Control reserved bits set.");

  property p_status_rd;
    @(posedge mclk) disable iff (sys_rst)
    s_ctrl_read |=> rdata[`VCC_STATUS_BIT] == $past(st.tbl_status);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("Status read wrong.");

  // The stored select reads back raw; only the applied scheme is sanitised.
  property p_sel_rd;
    @(posedge mclk) disable iff (sys_rst)
    s_ctrl_read |=> rdata[3:1] == $past(st.arb_sel);
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("Select read wrong.");

  property p_sel_store;
    @(posedge mclk) disable iff (sys_rst)
    wr && addr == `VCC_OFS_CTRL |=> st.arb_sel == $past(wdata[3:1]);
  endproperty
  a_sel_store: assert property (p_sel_store) else $error("Select not stored.");

  property p_sel_hold;
    @(posedge mclk) disable iff (sys_rst)
    !(wr && addr == `VCC_OFS_CTRL) |=> $stable(st.arb_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("Select changed without write.");

  property p_sel_good;
    @(posedge mclk) disable iff (sys_rst)
    wr && addr == `VCC_OFS_CTRL && wdata[3:1] <= 3'h1 |=> arb_scheme == $past(wdata[3:1]);
  endproperty
  a_sel_good: assert property (p_sel_good) else $error("Valid scheme not applied.");

  property p_scheme_range;
    @(posedge mclk) disable iff (sys_rst)
    arb_scheme <= 3'h1;
  endproperty
  a_scheme_range: assert property (p_scheme_range) else $error("Scheme out of range.");

  property p_status_hold;
    @(posedge mclk) disable iff (sys_rst)
    !tbl_entry_write && !tbl_load_done |=> $stable(st.tbl_status);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("Status changed alone.");

  // A table write racing with load completion must leave the flag set, else a write is lost.
  property p_set_wins;
    @(posedge mclk) disable iff (sys_rst)
    tbl_entry_write && tbl_load_done |=> st.tbl_status;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Set lost to clear.");

  property p_capture;
    @(posedge mclk) disable iff (sys_rst)
    log_event |=> st.hlog == $past(log_header);
  endproperty
  a_capture: assert property (p_capture) else $error("Header not captured.");
endmodule : vcc_regs

/* sim/vcc_regs_tb.sv */
// Directed register-port test of the channel capability register block.
`timescale 1ns/1ns
module vcc_regs_tb;
  logic         mclk;
  logic         sys_rst;
  logic [11:0]  addr;
  logic [31:0]  wdata;
  logic         wr;
  logic         rd;
  logic [31:0]  rdata;
  logic         log_event;
  logic [127:0] log_header;
  logic         strap_load;
  logic [2:0]   strap_ext_cnt;
  logic [2:0]   strap_low_cnt;
  logic         tbl_entry_write;
  logic         tbl_load_done;
  logic         tbl_load;
  logic [2:0]   arb_scheme;
  int           n_mismatch;
  int           n_checks;
  vcc_regs i_dut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .log_event(log_event), .log_header(log_header), .strap_load(strap_load), .strap_ext_cnt(strap_ext_cnt),
    .strap_low_cnt(strap_low_cnt), .tbl_entry_write(tbl_entry_write), .tbl_load_done(tbl_load_done),
    .tbl_load(tbl_load), .arb_scheme(arb_scheme));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    #100000 n_mismatch++;
    wrap_up();
  end
  initial
  begin
    {addr, wdata, wr, rd, log_event, strap_load, tbl_entry_write, tbl_load_done} = '0;
    {strap_ext_cnt, strap_low_cnt} = '0;
    log_header = {32'hDDCCBBAA, 32'h99887766, 32'h55443322, 32'h11223344};
    n_mismatch = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd_chk(12'h140, 32'h20C10002);
    rd_chk(12'h144, 32'h00000800);
    rd_chk(12'h148, 32'h00000000);
    rd_chk(12'h14C, 32'h00000000);
    wr_reg(12'h140, 32'hFFFFFFFF);
    rd_chk(12'h140, 32'h20C10002);
    rd_chk(12'h200, 32'h00000000);
    @(posedge mclk);
    log_event <= 1'b1;
    @(posedge mclk);
    log_event <= 1'b0;
    log_header <= '1;
    rd_chk(12'h11C, 32'h44332211);
    rd_chk(12'h120, 32'h22334455);
    rd_chk(12'h124, 32'h66778899);
    rd_chk(12'h128, 32'hAABBCCDD);
    @(posedge mclk);
    strap_load <= 1'b1;
    strap_ext_cnt <= 3'h1;
    strap_low_cnt <= 3'h2;
    @(posedge mclk);
    strap_load <= 1'b0;
    rd_chk(12'h144, 32'h00000821);
    rd_chk(12'h148, 32'h03000003);
    @(posedge mclk);
    tbl_entry_write <= 1'b1;
    @(posedge mclk);
    tbl_entry_write <= 1'b0;
    wr_reg(12'h14C, 32'h00000003);
    #1 chk({29'h0, tbl_load, arb_scheme[1:0]}, 32'h00000005);
    rd_chk(12'h14C, 32'h00010002);
    chk({31'h0, tbl_load}, 32'h00000000);
    @(posedge mclk);
    tbl_load_done <= 1'b1;
    @(posedge mclk);
    tbl_load_done <= 1'b0;
    rd_chk(12'h14C, 32'h00000002);
    wr_reg(12'h14C, 32'h0000000A);
    #1 chk({29'h0, arb_scheme}, 32'h00000000);
    @(posedge mclk);
    tbl_entry_write <= 1'b1;
    @(posedge mclk);
    tbl_entry_write <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd_chk(12'h14C, 32'h00000000);
    rd_chk(12'h144, 32'h00000800);
    rd_chk(12'h11C, 32'h00000000);
    wrap_up();
  end
endmodule : vcc_regs_tb
